/* File: pkg/rtcv_consts.svh */
// Purpose: Offsets, field positions and timing counts of the clock value block.
// Assumes: Included by its bare name from the package and the design.
// Notes: Byte addresses on the register bus; each register takes one word.
`ifndef RTCV_CONSTS_SVH
`define RTCV_CONSTS_SVH
`define RTCV_OFF_TIME 8'h00
`define RTCV_OFF_DATE 8'h04
`define RTCV_OFF_ATIME 8'h08
`define RTCV_OFF_ADATE 8'h0c
`define RTCV_OFF_CTRL 8'h10
`define RTCV_OFF_ACTRL 8'h14
`define RTCV_OFF_ISTAT 8'h18
`define RTCV_OFF_IMASK 8'h1c
`define RTCV_TIME_MASK 32'h3f7f7f00
`define RTCV_DATE_MASK 32'hff1f3f07
`define RTCV_ADATE_MASK 32'h001f3f07
`define RTCV_SEC_MASK 32'h00007f00
`define RTCV_CTRL_WREN_BIT 3
`define RTCV_CTRL_SYNC_BIT 2
`define RTCV_CTRL_HALF_BIT 1
`define RTCV_ACTRL_MASK 32'h0000000f
`define RTCV_HALF_NS 500000000
`define RTCV_CLK_NS 5
`define RTCV_SYNC_WINDOW 4
`endif

/* File: pkg/rtcv_pkg.sv */
// Purpose: Types shared by the clock value block.
// Assumes: Constants come from the header.
// Notes: Field structs follow the packed register layouts.
package rtcv_pkg;
   `include "rtcv_consts.svh"
   typedef struct packed {
      logic [1:0] hour_tens;
      logic [3:0] hour_units;
      logic [2:0] minute_tens;
      logic [3:0] minute_units;
      logic [2:0] second_tens;
      logic [3:0] second_units;
   } rtcv_time_t;
   typedef struct packed {
      logic [3:0] year_tens;
      logic [3:0] year_units;
      logic month_tens;
      logic [3:0] month_units;
      logic [1:0] date_tens;
      logic [3:0] date_units;
      logic [2:0] weekday_value;
   } rtcv_date_t;
   typedef enum logic [3:0] {
      RTCV_P_HALF = 4'h0, RTCV_P_SEC = 4'h1, RTCV_P_10SEC = 4'h2, RTCV_P_MIN = 4'h3,
      RTCV_P_10MIN = 4'h4, RTCV_P_HOUR = 4'h5, RTCV_P_DAY = 4'h6, RTCV_P_WEEK = 4'h7,
      RTCV_P_MONTH = 4'h8, RTCV_P_YEAR = 4'h9
   } rtcv_period_t;
endpackage

/* File: rtl/rtcv_values.sv */
// Purpose: Time, date and alarm value registers of a calendar clock, AXI4-Lite slave.
// Assumes: Single clock; software keeps the write-enable protocol.
// Notes: Value fields are not reset; control and interrupt state are.
`timescale 1ns/10ps
`include "rtcv_consts.svh"
// What this block does
// RL1: Time hours: tens 0-2 in bits 29-28, units in 27-24.
// RL2: Time minutes: tens 0-5 in bits 22-20, units in 19-16.
// RL3: Time seconds: tens 0-5 in bits 14-12, units in 11-8.
// RL4: Unused bits of the four value registers read as zero.
// RL5: Writes to running time and date ignored unless write enable set.
// RL6: Date year: tens digit bits 31-28, units digit bits 27-24.
// RL7: Date month: tens bit 20, units in bits 19-16.
// RL8: Date day: tens 0-3 in bits 13-12, units in bits 11-8.
// RL9: Weekday 0-6 in bits 2-0, bits 7-3 unused.
// RL10: Alarm time uses the running time layout.
// RL11: Alarm date holds month, day and weekday like the running date.
// RL12: Alarm date has no year; bits 31-21 read zero.
// RL13: Value fields have no defined value after reset.
// RL14: Control bit 3 set allows time and date writes; clear locks them.
// RL15: Writing the seconds fields clears the half-second flag.
// RL16: Alarm period code selects repeat interval; codes above 1001 reserved.
// RL17: Software reads twice while the ripple flag is set.
// RL18: Each second advance time and date with BCD rollovers and leap years.
// RL19: Alarm event when fields selected by the period code match.
module rtcv_values
   import rtcv_pkg::*;
#(
   parameter int unsigned HALF_CYCLES = `RTCV_HALF_NS / `RTCV_CLK_NS
)(
   // Clock, reset and enable.
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // AXI4-Lite write address and data.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt.
   output logic irq_o
);
   // Refuse a half-second count too short for the ripple window.
   if (HALF_CYCLES < 8) begin : half_check_g
      $error("HALF_CYCLES too small");
   end

   // Value storage, deliberately left without reset.
   rtcv_time_t cur_time; // RL13
   rtcv_date_t cur_date;
   rtcv_time_t alm_time;
   rtcv_date_t alm_date;
   // Control state.
   logic value_write_enable;
   logic half_second_flag;
   logic [3:0] alarm_period_code;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [31:0] half_cnt;
   // Bus state.
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Write channel: capture address and data in either order.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   wire aw_now = aw_held || s_axi_awvalid;
   wire w_now = w_held || s_axi_wvalid;
   wire do_wr = aw_now && w_now && !s_axi_bvalid;
   wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire [31:0] bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire wr_known = wr_addr[7:5] == 3'h0 && wr_addr[1:0] == 2'h0;

   // Per-register write strobes.
   wire wr_time = do_wr && wr_addr == `RTCV_OFF_TIME && value_write_enable; // RL5 RL14
   wire wr_date = do_wr && wr_addr == `RTCV_OFF_DATE && value_write_enable; // RL5 RL14
   wire wr_atime = do_wr && wr_addr == `RTCV_OFF_ATIME;
   wire wr_adate = do_wr && wr_addr == `RTCV_OFF_ADATE;
   wire wr_ctrl = do_wr && wr_addr == `RTCV_OFF_CTRL && wr_strb[0];
   wire wr_actrl = do_wr && wr_addr == `RTCV_OFF_ACTRL && wr_strb[0];
   wire wr_istat = do_wr && wr_addr == `RTCV_OFF_ISTAT && wr_strb[0];
   wire wr_imask = do_wr && wr_addr == `RTCV_OFF_IMASK && wr_strb[0];
   wire wr_sec = wr_time && (bmask & `RTCV_SEC_MASK) != 32'h0; // RL15

   // Merge function honours byte strobes and field masks.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] bm, input logic [31:0] fm);
      merge = ((old & ~bm) | (nw & bm)) & fm;
   endfunction

   // Register images with unused bits forced to zero.
   wire [31:0] time_img = {2'h0, cur_time[19:14], 1'h0, cur_time[13:7], 1'h0,
                           cur_time[6:0], 8'h00} & `RTCV_TIME_MASK; // RL1 RL2 RL3 RL4
   wire [31:0] date_img = {cur_date[21:14], 3'h0, cur_date[13:9], 2'h0, cur_date[8:3],
                           5'h00, cur_date[2:0]}; // RL6 RL7 RL8 RL9 RL4
   wire [31:0] atime_img = {2'h0, alm_time[19:14], 1'h0, alm_time[13:7], 1'h0,
                            alm_time[6:0], 8'h00} & `RTCV_TIME_MASK; // RL10
   wire [31:0] adate_img = {11'h000, alm_date[13:9], 2'h0, alm_date[8:3], 5'h00,
                            alm_date[2:0]}; // RL11 RL12
   wire [31:0] time_new = merge(time_img, wr_data, bmask, `RTCV_TIME_MASK);
   wire [31:0] date_new = merge(date_img, wr_data, bmask, `RTCV_DATE_MASK);
   wire [31:0] atime_new = merge(atime_img, wr_data, bmask, `RTCV_TIME_MASK);
   wire [31:0] adate_new = merge(adate_img, wr_data, bmask, `RTCV_ADATE_MASK);

   // Half-second timebase and ripple window.
   wire half_tick = half_cnt == HALF_CYCLES - 1;
   wire sec_tick = half_tick && half_second_flag;
   wire read_ripple_flag = half_second_flag && (half_cnt >= HALF_CYCLES - `RTCV_SYNC_WINDOW); // RL17

   wire month_end_31 = cur_date.month_units == 4'h1 || cur_date.month_units == 4'h3 ||
                       cur_date.month_units == 4'h5 || cur_date.month_units == 4'h7 ||
                       cur_date.month_units == 4'h8 || cur_date.month_tens;
   wire leap = cur_date.year_tens[0] ? (cur_date.year_units == 4'h2 || cur_date.year_units == 4'h6)
             : (cur_date.year_units == 4'h0 || cur_date.year_units == 4'h4 ||
                cur_date.year_units == 4'h8);
   wire is_feb = !cur_date.month_tens && cur_date.month_units == 4'h2;
   wire is_dec = cur_date.month_tens && cur_date.month_units == 4'h2;
   wire [7:0] day_bin = {6'h0, cur_date.date_tens} * 8'd10 + {4'h0, cur_date.date_units};
   wire [7:0] day_last = is_feb ? (leap ? 8'd29 : 8'd28)
                       : (cur_date.month_tens && cur_date.month_units == 4'h1) ? 8'd30
                       : (!cur_date.month_tens && (cur_date.month_units == 4'h4 ||
                          cur_date.month_units == 4'h6 || cur_date.month_units == 4'h9)) ? 8'd30
                       : month_end_31 ? 8'd31 : 8'd30;
   wire s_wrap = cur_time.second_tens == 3'h5 && cur_time.second_units == 4'h9;
   wire m_wrap = cur_time.minute_tens == 3'h5 && cur_time.minute_units == 4'h9;
   wire h_wrap = cur_time.hour_tens == 2'h2 && cur_time.hour_units == 4'h3;
   wire d_wrap = day_bin >= day_last;
   wire y_wrap = cur_date.year_tens == 4'h9 && cur_date.year_units == 4'h9;

   // Next running time and date one second on.
   rtcv_time_t next_time;
   rtcv_date_t next_date;
   always_comb begin
      next_time = cur_time;
      next_date = cur_date;
      // Seconds, minutes and hours with BCD rollover.
      if (s_wrap) begin // RL18
         next_time.second_tens = 3'h0;
         next_time.second_units = 4'h0;
         if (m_wrap) begin
            next_time.minute_tens = 3'h0;
            next_time.minute_units = 4'h0;
            if (h_wrap) begin
               next_time.hour_tens = 2'h0;
               next_time.hour_units = 4'h0;
               next_date.weekday_value = cur_date.weekday_value >= 3'h6 ? 3'h0
                                         : cur_date.weekday_value + 3'h1;
               if (d_wrap) begin
                  next_date.date_tens = 2'h0;
                  next_date.date_units = 4'h1;
                  if (is_dec) begin
                     next_date.month_tens = 1'b0;
                     next_date.month_units = 4'h1;
                     next_date.year_tens = y_wrap ? 4'h0 : (cur_date.year_units == 4'h9 ?
                                           cur_date.year_tens + 4'h1 : cur_date.year_tens);
                     next_date.year_units = cur_date.year_units == 4'h9 ? 4'h0
                                            : cur_date.year_units + 4'h1;
                  end else if (cur_date.month_units == 4'h9) begin
                     next_date.month_tens = 1'b1;
                     next_date.month_units = 4'h0;
                  end else begin
                     next_date.month_units = cur_date.month_units + 4'h1;
                  end
               end else if (cur_date.date_units == 4'h9) begin
                  next_date.date_tens = cur_date.date_tens + 2'h1;
                  next_date.date_units = 4'h0;
               end else begin
                  next_date.date_units = cur_date.date_units + 4'h1;
               end
            end else if (cur_time.hour_units == 4'h9) begin
               next_time.hour_tens = cur_time.hour_tens + 2'h1;
               next_time.hour_units = 4'h0;
            end else begin
               next_time.hour_units = cur_time.hour_units + 4'h1;
            end
         end else if (cur_time.minute_units == 4'h9) begin
            next_time.minute_tens = cur_time.minute_tens + 3'h1;
            next_time.minute_units = 4'h0;
         end else begin
            next_time.minute_units = cur_time.minute_units + 4'h1;
         end
      end else if (cur_time.second_units == 4'h9) begin
         next_time.second_tens = cur_time.second_tens + 3'h1;
         next_time.second_units = 4'h0;
      end else begin
         next_time.second_units = cur_time.second_units + 4'h1;
      end
   end

   // Alarm comparison by period code.
   wire eq_s1 = cur_time.second_units == alm_time.second_units;
   wire eq_s10 = eq_s1 && cur_time.second_tens == alm_time.second_tens;
   wire eq_m1 = eq_s10 && cur_time.minute_units == alm_time.minute_units;
   wire eq_m10 = eq_m1 && cur_time.minute_tens == alm_time.minute_tens;
   wire eq_h = eq_m10 && cur_time[19:14] == alm_time[19:14];
   wire eq_w = eq_h && cur_date.weekday_value == alm_date.weekday_value;
   wire eq_d = eq_h && cur_date[8:3] == alm_date[8:3];
   wire eq_y = eq_d && cur_date[13:9] == alm_date[13:9];
   logic alarm_match;
   always_comb begin
      case (alarm_period_code) // RL16 RL19
         RTCV_P_HALF: alarm_match = half_tick;
         RTCV_P_SEC: alarm_match = 1'b1;
         RTCV_P_10SEC: alarm_match = eq_s1;
         RTCV_P_MIN: alarm_match = eq_s10;
         RTCV_P_10MIN: alarm_match = eq_m1;
         RTCV_P_HOUR: alarm_match = eq_m10;
         RTCV_P_DAY: alarm_match = eq_h;
         RTCV_P_WEEK: alarm_match = eq_w;
         RTCV_P_MONTH: alarm_match = eq_d;
         RTCV_P_YEAR: alarm_match = eq_y;
         default: alarm_match = 1'b0;
      endcase
   end
   wire alarm_evt = (alarm_period_code == RTCV_P_HALF) ? half_tick
                    : (sec_tick && alarm_match); // RL19
   wire [1:0] evt = {sec_tick, alarm_evt};
   wire [1:0] next_stat = (irq_stat & ~(wr_istat ? wr_data[1:0] : 2'h0)) | evt;

   // Value registers: software write wins over the running advance.
   always_ff @(posedge clk_sys_i) begin
      if (clk_en_i) begin
         if (wr_time) begin // RL5
            cur_time <= rtcv_time_t'({time_new[29:24], time_new[22:16], time_new[14:8]});
         end else if (sec_tick) begin // RL18
            cur_time <= next_time;
         end
         if (wr_date) begin // RL5
            cur_date <= rtcv_date_t'({date_new[31:24], date_new[20:16], date_new[13:8],
                                      date_new[2:0]});
         end else if (sec_tick && s_wrap && m_wrap && h_wrap) begin
            cur_date <= next_date;
         end
         if (wr_atime) begin
            alm_time <= rtcv_time_t'({atime_new[29:24], atime_new[22:16], atime_new[14:8]});
         end
         if (wr_adate) begin
            alm_date <= rtcv_date_t'({8'h00, adate_new[20:16], adate_new[13:8],
                                      adate_new[2:0]});
         end
      end
   end

   // Control, timebase and interrupt state.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         value_write_enable <= 1'b0;
         half_second_flag <= 1'b0;
         alarm_period_code <= 4'h0;
         half_cnt <= 32'h0;
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else if (clk_en_i) begin
         if (wr_ctrl) begin
            value_write_enable <= wr_data[`RTCV_CTRL_WREN_BIT]; // RL14
         end
         if (wr_sec) begin // RL15
            half_second_flag <= 1'b0;
            half_cnt <= 32'h0;
         end else if (half_tick) begin
            half_second_flag <= !half_second_flag;
            half_cnt <= 32'h0;
         end else begin
            half_cnt <= half_cnt + 32'h1;
         end
         if (wr_actrl) begin
            alarm_period_code <= wr_data[3:0];
         end
         irq_stat <= next_stat;
         if (wr_imask) begin
            irq_mask <= wr_data[1:0];
         end
      end
   end

   // Write channel holding registers and response.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (clk_en_i) begin
         if (do_wr) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
            end
            if (s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // Read decode.
   assign s_axi_arready = !s_axi_rvalid;
   wire [31:0] ctrl_img = {28'h0, value_write_enable, read_ripple_flag, half_second_flag, 1'b0};
   wire [7:0] ra = s_axi_araddr;
   wire [31:0] rd_mux = ra == `RTCV_OFF_TIME ? time_img
                      : ra == `RTCV_OFF_DATE ? date_img
                      : ra == `RTCV_OFF_ATIME ? atime_img
                      : ra == `RTCV_OFF_ADATE ? adate_img
                      : ra == `RTCV_OFF_CTRL ? ctrl_img
                      : ra == `RTCV_OFF_ACTRL ? {28'h0, alarm_period_code}
                      : ra == `RTCV_OFF_ISTAT ? {30'h0, irq_stat}
                      : ra == `RTCV_OFF_IMASK ? {30'h0, irq_mask} : 32'h0;
   wire rd_known = ra[7:5] == 3'h0 && ra[1:0] == 2'h0;

   // Read data register.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (clk_en_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // Checks.
   locked_time_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL5
      clk_en_i && !value_write_enable && !sec_tick |=> time_img === $past(time_img))
      else $error("time changed while locked");
   time_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL4
      clk_en_i && s_axi_arvalid && s_axi_arready && s_axi_araddr == `RTCV_OFF_TIME |=>
      (s_axi_rdata & ~`RTCV_TIME_MASK) == 32'h0) else $error("time unused bits set");
   adate_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL12
      clk_en_i && s_axi_arvalid && s_axi_arready && s_axi_araddr == `RTCV_OFF_ADATE |=>
      s_axi_rdata[31:21] == 11'h0) else $error("alarm date high bits set");
   half_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL15
      clk_en_i && wr_sec |=> !half_second_flag) else $error("half flag not cleared");
   wday_wrap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL18
      clk_en_i && sec_tick && s_wrap && m_wrap && h_wrap && !wr_date &&
      cur_date.weekday_value == 3'h6 |=> cur_date.weekday_value == 3'h0)
      else $error("weekday wrap wrong");
   sec_wrap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL3
      clk_en_i && sec_tick && s_wrap && !wr_time |=> time_img[14:8] == 7'h00)
      else $error("seconds wrap wrong");
   reserved_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL16
      alarm_period_code > 4'h9 |-> !alarm_evt) else $error("reserved code fired");
   wren_ctrl_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL14
      clk_en_i && wr_ctrl |=> value_write_enable == $past(wr_data[3]))
      else $error("write enable not stored");
   irq_level_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && alarm_evt && irq_mask[0] && !wr_imask |=> irq_o)
      else $error("irq not raised by alarm");
endmodule

/* File: test/rtcv_values_tb.sv */
// Purpose: Self-checking bench for the clock value registers over AXI4-Lite.
// Assumes: Short half-second count so that ticks and rollovers come quickly.
// Notes: Each tick is 2*HALF cycles away after a seconds write, so reads just after it are stable.
`timescale 1ns/10ps
`include "rtcv_consts.svh"
module rtcv_values_tb;
   import rtcv_pkg::*;
   localparam int HALF = 64;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failures = 0;
   int n_checks = 0;
   logic [31:0] t, d, a, rt [3], rd [3], et [3], ed [3];
   // The block under test, with a short half-second count.
   rtcv_values #(.HALF_CYCLES(HALF)) rtcv_values_i (.clk_sys_i, .reset_i, .clk_en_i,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq_o);
   // Free-running 200 MHz clock.
   always #2.5 clk_sys_i = ~clk_sys_i;
   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Compares one word and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Writes one word; address and data are released each as it is taken.
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er = 2'b00);
      @(posedge clk_sys_i);
      s_axi_awaddr <= ad;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= dt;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   // Reads one word and compares the masked data and the response.
   task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er = 2'b00);
      @(posedge clk_sys_i);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(nm, e, s_axi_rdata & m);
      chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   // Looks at the interrupt once the edge's updates have landed.
   task automatic chk_irq(input logic e);
      @(negedge clk_sys_i);
      chk("irq", {31'h0, e}, {31'h0, irq_o});
   endtask
   // Random legal time in register layout.
   function automatic logic [31:0] rnd_time();
      logic [1:0] ht;
      ht = 2'($urandom_range(2));
      return {2'b00, ht, 4'($urandom_range(ht == 2'd2 ? 3 : 9)), 1'b0, 3'($urandom_range(5)),
              4'($urandom_range(9)), 1'b0, 3'($urandom_range(5)), 4'($urandom_range(9)), 8'h00};
   endfunction
   // Random legal date in register layout.
   function automatic logic [31:0] rnd_date();
      return {4'($urandom_range(9)), 4'($urandom_range(9)), 4'h0, 4'($urandom_range(9, 1)),
              2'b00, 2'($urandom_range(2)), 4'($urandom_range(8, 1)), 5'h0,
              3'($urandom_range(6))};
   endfunction
   // Watchdog against a hung handshake.
   initial begin
      repeat (30000) @(posedge clk_sys_i);
      failures++;
      finish_test();
   end
   // Main sequence.
   initial begin
      void'($urandom(71));
      rt = '{32'h23595900, 32'h23595900, 32'h23595900};
      rd = '{32'h23022806, 32'h24022803, 32'h99123102};
      et = '{32'h00000000, 32'h00000000, 32'h00000000};
      ed = '{32'h23030100, 32'h24022904, 32'h00010103};
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      rdc("ctrl wren", `RTCV_OFF_CTRL, 32'h8, 32'h0);
      rdc("status", `RTCV_OFF_ISTAT, 32'h3, 32'h0);
      chk_irq(1'b0);
      rdc("unmapped", 8'h20, 32'hffffffff, 32'h0, 2'b10);
      rdc("unaligned", 8'h02, 32'hffffffff, 32'h0, 2'b10);
      wr(8'h24, 32'h1, 2'b10);
      for (int i = 0; i < 6; i++) begin
         t = rnd_time();
         d = rnd_date();
         wr(`RTCV_OFF_CTRL, 32'h8);
         wr(`RTCV_OFF_TIME, t | ($urandom() & ~`RTCV_TIME_MASK));
         wr(`RTCV_OFF_DATE, d | ($urandom() & ~`RTCV_DATE_MASK));
         rdc("time", `RTCV_OFF_TIME, 32'hffffffff, t);
         rdc("date", `RTCV_OFF_DATE, 32'hffffffff, d);
         wr(`RTCV_OFF_CTRL, 32'h0);
         wr(`RTCV_OFF_TIME, rnd_time());
         wr(`RTCV_OFF_DATE, rnd_date());
         rdc("locked time", `RTCV_OFF_TIME, 32'hffffffff, t);
         rdc("locked date", `RTCV_OFF_DATE, 32'hffffffff, d);
         a = rnd_time();
         d = rnd_date();
         wr(`RTCV_OFF_ATIME, a | ($urandom() & ~`RTCV_TIME_MASK));
         wr(`RTCV_OFF_ADATE, d | ($urandom() & ~`RTCV_ADATE_MASK));
         rdc("alarm time", `RTCV_OFF_ATIME, 32'hffffffff, a);
         rdc("alarm date", `RTCV_OFF_ADATE, 32'hffffffff, d & `RTCV_ADATE_MASK);
      end
      wr(`RTCV_OFF_CTRL, 32'h8);
      wr(`RTCV_OFF_TIME, 32'h01020300);
      repeat (HALF + 4) @(posedge clk_sys_i);
      rdc("half flag set", `RTCV_OFF_CTRL, 32'h6, 32'h2);
      wr(`RTCV_OFF_TIME, 32'h01020300);
      rdc("half flag cleared", `RTCV_OFF_CTRL, 32'h2, 32'h0);
      // Land the next read a few cycles before the coming second rollover.
      repeat (2 * HALF - 8) @(posedge clk_sys_i);
      rdc("ripple flag", `RTCV_OFF_CTRL, 32'h6, 32'h6);
      for (int i = 0; i < 3; i++) begin
         wr(`RTCV_OFF_TIME, rt[i]);
         wr(`RTCV_OFF_DATE, rd[i]);
         repeat (2 * HALF + 8) @(posedge clk_sys_i);
         rdc("rolled time", `RTCV_OFF_TIME, 32'hffffffff, et[i]);
         rdc("rolled date", `RTCV_OFF_DATE, 32'hffffffff, ed[i]);
      end
      wr(`RTCV_OFF_IMASK, 32'h1);
      for (int c = 0; c < 12; c++) begin
         wr(`RTCV_OFF_TIME, 32'h12345600);
         wr(`RTCV_OFF_DATE, 32'h25061503);
         wr(`RTCV_OFF_ATIME, 32'h12344600);
         wr(`RTCV_OFF_ADATE, 32'h00061503);
         wr(`RTCV_OFF_ISTAT, 32'h3);
         wr(`RTCV_OFF_ACTRL, 32'(c));
         repeat (2 * HALF + 8) @(posedge clk_sys_i);
         rdc("alarm event", `RTCV_OFF_ISTAT, 32'h3, {30'h0, 1'b1, c <= 2});
         chk_irq(c <= 2);
         if (c <= 2) begin
            wr(`RTCV_OFF_IMASK, 32'h0);
            chk_irq(1'b0);
            wr(`RTCV_OFF_IMASK, 32'h1);
            chk_irq(1'b1);
            wr(`RTCV_OFF_ISTAT, 32'h1);
            chk_irq(1'b0);
         end
      end
      // A low clock enable must hold the timebase and the running time.
      wr(`RTCV_OFF_TIME, 32'h12345600);
      @(posedge clk_sys_i) clk_en_i <= 1'b0;
      repeat (3 * HALF) @(posedge clk_sys_i);
      clk_en_i <= 1'b1;
      rdc("frozen time", `RTCV_OFF_TIME, 32'hffffffff, 32'h12345600);
      finish_test();
   end
endmodule
